// ==== rtl/stl_pkg.sv ====
// Purpose: shared constants for the self-test results log
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   result codes and function codes follow the drive command set
package stl_pkg;
  localparam int          LOG_DEPTH  = 20;  // entries kept in the log
  localparam int          IDX_W      = 5;   // bits to index the log
  localparam logic [4:0]  LOG_MAX    = 5'd20;
  // register byte offsets
  localparam logic [7:0]  OFS_CMD    = 8'h00;  // write: function code
  localparam logic [7:0]  OFS_STAT   = 8'h04;  // read: running, count
  localparam logic [7:0]  OFS_IRQ    = 8'h08;  // sticky events, w1c
  localparam logic [7:0]  OFS_MASK   = 8'h0c;  // interrupt mask
  localparam logic [7:0]  OFS_SEL    = 8'h10;  // entry select, 0 newest
  localparam logic [7:0]  OFS_ENTRY  = 8'h14;  // selected entry codes
  localparam logic [7:0]  OFS_LBA    = 8'h18;  // selected entry lba
  // function codes
  localparam logic [2:0]  FN_SHORT   = 3'h1;
  localparam logic [2:0]  FN_EXT     = 3'h2;
  localparam logic [2:0]  FN_ABORT   = 3'h4;
  // result codes
  localparam logic [3:0]  RES_PASS   = 4'h0;
  localparam logic [3:0]  RES_ABORT  = 4'h1;
  localparam logic [3:0]  RES_RESET  = 4'h2;
  localparam logic [3:0]  RES_RUN    = 4'hf;
  // interrupt bits
  localparam int          IRQ_W      = 3;
  localparam int          IRQ_START  = 0;
  localparam int          IRQ_DONE   = 1;
  localparam int          IRQ_STOP   = 2;
  // entry word field positions
  localparam int          F_FN       = 0;   // [2:0]
  localparam int          F_RES      = 4;   // [7:4]
  localparam int          F_SK       = 8;   // [11:8]
  localparam int          F_ASC      = 16;  // [23:16]
  localparam int          F_ASCQ     = 24;  // [31:24]
  localparam int          F_FRU      = 8;   // status word [15:8]
  localparam int          F_RUNB     = 0;   // status bit running
  localparam int          F_CNT      = 16;  // status [20:16]
  // controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } stl_state_t;
endpackage : stl_pkg

// ==== rtl/stl_log.sv ====
// Operation
// - new entry at head, older shift down
// - keep 20 entries, drop the oldest
// - entry function code equals command's code
// - new entry result starts at f
// - store whole log after creating entry
// - final result written and stored at end
// - host reads up to 20, newest first
// - 4-bit result, zero pass, nonzero cause
// - failures record lba, sense, asc, ascq, fru
// - bus or device reset stops test
// - abort code records result 01
// - other stops record result 02
// - code 001 short, 010 extended
//
// Purpose: self-test results log with APB access and nv commit strobe
// Assumes: test engine on pclk; reset pins asynchronous to pclk
// Notes:   prdata is loaded in the setup phase, so pready stays high
//          a reset pin edge reaches the log three clocks after it rises
`timescale 1ns/100ps
`default_nettype none
module stl_log
  import stl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_reset,    // interface reset pin
  input  wire logic        dev_reset,    // device reset message pin
  input  wire logic        done_valid,   // engine: test finished
  input  wire logic [3:0]  done_result,
  input  wire logic [3:0]  done_sense,
  input  wire logic [7:0]  done_asc,
  input  wire logic [7:0]  done_ascq,
  input  wire logic [7:0]  done_fru,
  input  wire logic [31:0] done_lba,
  output var  logic        test_start,   // pulse to engine
  output var  logic [2:0]  test_func,
  output var  logic        test_stop,    // pulse: engine must halt
  output var  logic        nv_store,     // pulse: commit whole log
  output logic             irq
);
  import stl_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // log storage, index 0 is the newest entry
  // fields kept as separate arrays so a test end rewrites only the head entry
  // result and, on a failure, its detail, without touching the shift path of the older entries
  logic [2:0]  fn   [LOG_DEPTH];   // function code
  logic [3:0]  res  [LOG_DEPTH];   // result code
  logic [3:0]  sk   [LOG_DEPTH];   // sense key
  logic [7:0]  asc  [LOG_DEPTH];
  logic [7:0]  ascq [LOG_DEPTH];
  logic [7:0]  fru  [LOG_DEPTH];
  logic [31:0] lba  [LOG_DEPTH];
  logic [4:0]  count;              // valid entries
  stl_state_t  state;
  logic [IRQ_W-1:0] irq_stat;      // sticky events
  logic [IRQ_W-1:0] irq_mask;      // 1 lets the event through
  logic [4:0]  sel;                // entry picked for reading

  //////////////////////////////////////////////////////////////////////
  // reset pins: two flops, then a third for the edge
  // the pins are not timed to pclk; the first flop feeds no logic, and
  // a held level counts once, so a long reset pulse stops one test only
  logic [1:0] brs_q, drs_q;
  logic       brs_d, drs_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brs_q <= 2'h0;
      drs_q <= 2'h0;
      brs_d <= 1'b0;
      drs_d <= 1'b0;
    end else begin
      brs_q <= {brs_q[0], bus_reset};
      drs_q <= {drs_q[0], dev_reset};
      brs_d <= brs_q[1];
      drs_d <= drs_q[1];
    end
  end
  wire rst_ev = (brs_q[1] & ~brs_d) | (drs_q[1] & ~drs_d);

  //////////////////////////////////////////////////////////////////////
  // bus decode
  // setup and access are told apart by penable; the slave never stalls
  wire wr_acc  = psel & penable & pwrite;
  wire setup   = psel & ~penable;
  wire hit_cmd = (paddr == OFS_CMD);
  wire hit_st  = (paddr == OFS_STAT);
  wire hit_irq = (paddr == OFS_IRQ);
  wire hit_msk = (paddr == OFS_MASK);
  wire hit_sel = (paddr == OFS_SEL);
  wire hit_ent = (paddr == OFS_ENTRY);
  wire hit_lba = (paddr == OFS_LBA);
  wire mapped  = hit_cmd | hit_st | hit_irq | hit_msk | hit_sel
               | hit_ent | hit_lba;
  wire running = (state == ST_RUN);
  wire [2:0] wr_fn = pwdata[2:0];
  // only the two test codes open an entry; busy drive ignores them
  wire fn_test  = (wr_fn == FN_SHORT) | (wr_fn == FN_EXT);
  wire start_ok = wr_acc & hit_cmd & fn_test & ~running;
  wire abort_ok = wr_acc & hit_cmd & (wr_fn == FN_ABORT) & running
                & ~rst_ev;
  wire reset_ok = rst_ev & running;
  // engine completion counts only while a test is open
  wire done_ok  = done_valid & running & ~abort_ok & ~reset_ok;
  wire end_ok   = done_ok | abort_ok | reset_ok;
  wire [3:0] end_res = abort_ok ? RES_ABORT
                     : reset_ok ? RES_RESET : done_result;
  wire fail_rec = done_ok & (done_result != RES_PASS);
  wire [IRQ_W-1:0] ev = {(abort_ok | reset_ok), done_ok, start_ok};
  wire sel_ok   = (sel < count);

  //////////////////////////////////////////////////////////////////////
  // entry shifting and update; head only is rewritten at test end
  // a start and an end cannot meet: a start needs idle, an end a test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < LOG_DEPTH; i++) begin
        fn[i]   <= 3'h0;
        res[i]  <= RES_PASS;
        sk[i]   <= 4'h0;
        asc[i]  <= 8'h00;
        ascq[i] <= 8'h00;
        fru[i]  <= 8'h00;
        lba[i]  <= 32'h0;
      end
    end else if (start_ok) begin
      // tail entry falls off the end as all move down
      for (int i = LOG_DEPTH-1; i > 0; i--) begin
        fn[i]   <= fn[i-1];
        res[i]  <= res[i-1];
        sk[i]   <= sk[i-1];
        asc[i]  <= asc[i-1];
        ascq[i] <= ascq[i-1];
        fru[i]  <= fru[i-1];
        lba[i]  <= lba[i-1];
      end
      fn[0]   <= wr_fn;
      res[0]  <= RES_RUN;
      sk[0]   <= 4'h0;
      asc[0]  <= 8'h00;
      ascq[0] <= 8'h00;
      fru[0]  <= 8'h00;
      lba[0]  <= 32'h0;
    end else if (end_ok) begin
      res[0] <= end_res;
      if (fail_rec) begin
        sk[0]   <= done_sense;
        asc[0]  <= done_asc;
        ascq[0] <= done_ascq;
        fru[0]  <= done_fru;
        lba[0]  <= done_lba;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // count saturates at the depth
  // once full, each new entry pushes one out, so the count stays put
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) count <= 5'd0;
    else if (start_ok && count != LOG_MAX) count <= count + 5'd1;
  end

  //////////////////////////////////////////////////////////////////////
  // controller
  // two states only: the engine does the work, this side keeps the books
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (start_ok) state <= ST_RUN;
        ST_RUN:  if (end_ok) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // engine strobes and nv commit, one cycle each
  // the storage side copies the whole log on every strobe; a start and
  // the end of the same test always give two separate strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_start <= 1'b0;
      test_func  <= 3'h0;
      test_stop  <= 1'b0;
      nv_store   <= 1'b0;
    end else begin
      test_start <= start_ok;
      test_stop  <= abort_ok | reset_ok;
      nv_store   <= start_ok | end_ok;
      if (start_ok) test_func <= wr_fn;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // control registers; an event beats a clear in the same cycle
  // so software clearing a bit it has just read never loses a fresh event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
      sel      <= 5'd0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_acc & hit_irq) ? pwdata[IRQ_W-1:0]
                                                    : '0)) | ev;
      if (wr_acc && hit_msk) irq_mask <= pwdata[IRQ_W-1:0];
      if (wr_acc && hit_sel) sel <= pwdata[4:0];
    end
  end
  assign irq = |(irq_stat & irq_mask);

  //////////////////////////////////////////////////////////////////////
  // read data; entries beyond count read as zero
  // sel may point past the last entry; the guard keeps the array index
  // in range, so stale or unknown words never reach the bus
  logic [31:0] rd_st, rd_ent, rd_lba, rd_mux;
  always_comb begin
    rd_st  = 32'h0;
    rd_ent = 32'h0;
    rd_lba = 32'h0;
    rd_st[F_RUNB]         = running;
    rd_st[F_CNT +: 5]     = count;
    if (sel_ok) begin
      rd_ent[F_FN +: 3]   = fn[sel];
      rd_ent[F_RES +: 4]  = res[sel];
      rd_ent[F_SK +: 4]   = sk[sel];
      rd_ent[F_ASC +: 8]  = asc[sel];
      rd_ent[F_ASCQ +: 8] = ascq[sel];
      rd_lba              = lba[sel];
      rd_st[F_FRU +: 8]   = fru[sel];
    end
  end
  assign rd_mux = hit_st  ? rd_st
                : hit_irq ? {29'h0, irq_stat}
                : hit_msk ? {29'h0, irq_mask}
                : hit_sel ? {27'h0, sel}
                : hit_ent ? rd_ent
                : hit_lba ? rd_lba : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (setup) prdata <= rd_mux;
  end
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  //////////////////////////////////////////////////////////////////////
  // checks
  // each property guards one rule of the log; all share the bus clock
  // and are off while the block is held in reset
  a_head_init: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok |=> fn[0] == $past(pwdata[2:0]) && res[0] == RES_RUN)
    else $error("new entry not initialised");
  a_shift_down: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok |=> res[1] == $past(res[0]) && fn[1] == $past(fn[0]))
    else $error("log did not shift");
  a_count_cap: assert property (@(posedge pclk) disable iff (!presetn)
    count <= LOG_MAX)
    else $error("log count above depth");
  a_nv_commit: assert property (@(posedge pclk) disable iff (!presetn)
    (start_ok || end_ok) |=> nv_store)
    else $error("log not committed");
  // no commit strobe without a new entry or a finished test
  a_nv_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !(start_ok || end_ok) |=> !nv_store)
    else $error("stray commit strobe");
  a_done_res: assert property (@(posedge pclk) disable iff (!presetn)
    done_ok |=> res[0] == $past(done_result) && !running)
    else $error("final result not stored");
  a_abort_res: assert property (@(posedge pclk) disable iff (!presetn)
    abort_ok |=> res[0] == RES_ABORT && test_stop)
    else $error("abort code wrong");
  a_reset_res: assert property (@(posedge pclk) disable iff (!presetn)
    reset_ok |=> res[0] == RES_RESET && state == ST_IDLE)
    else $error("reset stop code wrong");
  a_older_kept: assert property (@(posedge pclk) disable iff (!presetn)
    end_ok |=> res[1] == $past(res[1]))
    else $error("older entry changed");
  a_fail_info: assert property (@(posedge pclk) disable iff (!presetn)
    fail_rec |=> lba[0] == $past(done_lba) && fru[0] == $past(done_fru))
    else $error("failure detail lost");

  //////////////////////////////////////////////////////////////////////
  // strobes to the engine, the entry counter and the read path; each
  // one catches a slip that the bench could only see much later
  // the engine is told the very code that opened the entry
  a_start_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok |=> test_start && test_func == $past(wr_fn))
    else $error("start strobe wrong");
  // the held function code always matches the open entry
  a_func_held: assert property (@(posedge pclk) disable iff (!presetn)
    running |-> test_func == fn[0])
    else $error("function code drifted");
  // an open test always shows the in-progress code
  a_run_marked: assert property (@(posedge pclk) disable iff (!presetn)
    running |-> res[0] == RES_RUN)
    else $error("open entry not marked");
  // a new entry carries no failure detail from an older test
  a_clean_head: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok |=> sk[0] == '0 && asc[0] == '0 && lba[0] == '0)
    else $error("new entry not clean");
  // the last slot takes its neighbour, the old tail is gone
  a_tail_shift: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok |=> lba[LOG_DEPTH-1] == $past(lba[LOG_DEPTH-2]))
    else $error("tail not shifted");
  // the count follows every new entry until the log is full
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok && count != LOG_MAX |=> count == $past(count) + 5'd1)
    else $error("count did not step");
  // a full log stays full
  a_full_hold: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok && count == LOG_MAX |=> count == LOG_MAX)
    else $error("full count moved");
  // a test code written while a test runs leaves the open entry alone
  a_busy_keep: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && hit_cmd && fn_test && running |=> fn[0] == $past(fn[0]))
    else $error("busy start accepted");
  // an abort with nothing running is ignored
  a_abort_idle: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && hit_cmd && wr_fn == FN_ABORT && !running |=> !running && !test_stop)
    else $error("idle abort acted");
  // the engine is halted only for an abort or a reset
  a_stop_once: assert property (@(posedge pclk) disable iff (!presetn)
    !(abort_ok || reset_ok) |=> !test_stop)
    else $error("stray halt strobe");
  // a reset stop halts the engine and commits the log
  a_reset_stop: assert property (@(posedge pclk) disable iff (!presetn)
    reset_ok |=> test_stop && nv_store)
    else $error("reset stop not sent");
  // entries past the count read as zero
  a_empty_read: assert property (@(posedge pclk) disable iff (!presetn)
    !sel_ok |-> rd_ent == '0 && rd_lba == '0)
    else $error("empty entry not zero");
endmodule : stl_log
`default_nettype wire

// ==== test/stl_engine.sv ====
// Purpose: behavioural test engine standing behind the results log
// Assumes: one pclk domain, counts dly cycles then reports res
// Notes:   outcome lines carry junk while done_valid is low
`timescale 1ns/100ps
`default_nettype none
module stl_engine (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        test_start,
  input  wire logic        test_stop,
  input  wire logic [7:0]  dly,
  input  wire logic [3:0]  res,
  output var  logic        done_valid,
  output logic [3:0]       done_result,
  output logic [3:0]       done_sense,
  output logic [7:0]       done_asc,
  output logic [7:0]       done_ascq,
  output logic [7:0]       done_fru,
  output logic [31:0]      done_lba
);
  logic       busy;  // a test is running
  logic [7:0] cnt;   // cycles left
  //////////////////////////////////////////////////////////////////////
  // halt wins over start so an abort never reports a late finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      cnt        <= 8'h00;
      done_valid <= 1'b0;
    end else begin
      done_valid <= 1'b0;
      if (test_stop) begin
        busy <= 1'b0;
      end else if (test_start) begin
        busy <= 1'b1;
        cnt  <= dly;
      end else if (busy && cnt == 8'h00) begin
        busy       <= 1'b0;
        done_valid <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
  // inverse values outside the strobe so stale data is never a match
  assign done_result = done_valid ? res : ~res;
  assign done_sense  = done_valid ? 4'h3 : 4'hc;
  assign done_asc    = done_valid ? 8'h11 : 8'hee;
  assign done_ascq   = done_valid ? 8'h01 : 8'hfe;
  assign done_fru    = done_valid ? 8'h0a : 8'hf5;
  assign done_lba    = done_valid ? 32'h0000_1234 : 32'hffff_edcb;
endmodule : stl_engine
`default_nettype wire

// ==== test/stl_log_tb.sv ====
// Purpose: self-checking bench for the self-test results log
// Assumes: zero-wait apb slave, engine model on the far side
// Notes:   a local history queue predicts every log entry
`timescale 1ns/100ps
`default_nettype none
module stl_log_tb;
  import stl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, e_dly, done_asc, done_ascq, done_fru;
  logic [31:0] pwdata, prdata, done_lba, q;
  logic        bus_reset, dev_reset, done_valid, test_start, test_stop;
  logic        nv_store, irq, slverr;
  logic [3:0]  e_res, done_result, done_sense;
  logic [2:0]  test_func;
  logic [7:0]  hist[$];  // expected entries, newest first
  int          fails, n_compared, nv_cnt, stop_cnt, i;
  stl_log DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus_reset, .dev_reset, .done_valid,
    .done_result, .done_sense, .done_asc, .done_ascq, .done_fru, .done_lba,
    .test_start, .test_func, .test_stop, .nv_store, .irq);
  stl_engine eng (.pclk, .presetn, .test_start, .test_stop, .dly(e_dly),
    .res(e_res), .done_valid, .done_result, .done_sense, .done_asc,
    .done_ascq, .done_fru, .done_lba);
  //////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // count commit and halt strobes
  always @(posedge pclk) if (nv_store === 1'b1) nv_cnt++;
  always @(posedge pclk) if (test_stop === 1'b1) stop_cnt++;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer; waits on pready, bounded only by the watchdog
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count is assumed; only the watchdog ends a hung wait
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    slverr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // k: 0 engine ends, 1 abort code, 2 bus reset, 3 device reset
  task automatic run(input logic [2:0] fn, input int k, input logic [3:0] r);
    int c0, s0;
    logic [3:0] x;
    c0 = nv_cnt;
    s0 = stop_cnt;
    e_res <= r;
    e_dly <= (k == 0) ? 8'd12 : 8'd200;
    apb(1'b1, OFS_SEL, 32'h0, q);
    apb(1'b1, OFS_CMD, {29'h0, fn}, q);
    apb(1'b0, OFS_ENTRY, 32'h0, q);
    chk({24'h0, q[7:0]}, {24'h0, RES_RUN, 1'b0, fn});
    chk({29'h0, test_func}, {29'h0, fn});
    if (k == 1) apb(1'b1, OFS_CMD, {29'h0, FN_SHORT}, q); // refused
    if (k == 1) apb(1'b1, OFS_CMD, {29'h0, FN_ABORT}, q);
    if (k > 1) begin
      if (k == 2) bus_reset <= 1'b1; else dev_reset <= 1'b1;
      repeat (3) @(posedge pclk);
      bus_reset <= 1'b0;
      dev_reset <= 1'b0;
    end
    // poll until idle; a test that never ends runs into the watchdog
    do apb(1'b0, OFS_STAT, 32'h0, q); while (q[0] !== 1'b0);
    x = (k == 1) ? RES_ABORT : (k > 1) ? RES_RESET : r;
    apb(1'b0, OFS_ENTRY, 32'h0, q);
    chk({24'h0, q[7:0]}, {24'h0, x, 1'b0, fn});
    chk(nv_cnt - c0, 2);
    chk(stop_cnt - s0, (k > 0) ? 1 : 0);
    hist.push_front({x, 1'b0, fn});
    if (hist.size() > LOG_DEPTH) void'(hist.pop_back());
  endtask : run
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    give_verdict();
  end
  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    bus_reset = 1'b0;
    dev_reset = 1'b0;
    e_dly     = 8'h00;
    e_res     = 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // an abort with nothing running must leave the log empty and idle
    apb(1'b1, OFS_CMD, {29'h0, FN_ABORT}, q);
    apb(1'b0, OFS_STAT, 32'h0, q);
    chk(q, 32'h0);
    chk(stop_cnt, 0);
    apb(1'b0, 8'h1c, 32'h0, q);
    chk(q, 32'h0);
    chk({31'h0, slverr}, 32'h1);
    run(FN_SHORT, 0, RES_PASS);
    apb(1'b0, OFS_IRQ, 32'h0, q);
    chk(q, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_MASK, 32'h2, q);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_IRQ, 32'h7, q);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    run(FN_EXT, 0, 4'h3);
    apb(1'b0, OFS_ENTRY, 32'h0, q);
    chk(q, 32'h0111_0332);
    apb(1'b0, OFS_LBA, 32'h0, q);
    chk(q, 32'h0000_1234);
    apb(1'b0, OFS_STAT, 32'h0, q);
    chk(q, 32'h0002_0a00);
    run(FN_EXT, 1, RES_PASS);
    run(FN_SHORT, 2, RES_PASS);
    run(FN_EXT, 3, RES_PASS);
    for (i = 0; i < 20; i++) run(i[0] ? FN_SHORT : FN_EXT, 0, {1'b0, i[2:0]});
    apb(1'b0, OFS_STAT, 32'h0, q);
    chk({27'h0, q[20:16]}, {27'h0, LOG_MAX});
    for (i = 0; i <= LOG_DEPTH; i++) begin
      apb(1'b1, OFS_SEL, i, q);
      apb(1'b0, OFS_ENTRY, 32'h0, q);
      chk({24'h0, q[7:0]}, {24'h0, (i < hist.size()) ? hist[i] : 8'h00});
    end
    give_verdict();
  end
endmodule : stl_log_tb
`default_nettype wire
